// File: src/itv_pkg.sv
// constants and types shared by the interrupt and trap vectoring block
package itv_pkg;

	// node counts and widths
	localparam int NODES = 16;
	localparam int NSTD  = 12;
	localparam int NMUX  = 4;
	localparam int NXEVT = 14;

	// register port offsets
	localparam logic [7:0] ADR_NODE0 = 8'h00;
	localparam logic [7:0] ADR_MUX0  = 8'h10;
	localparam logic [7:0] ADR_TFR   = 8'h14;
	localparam logic [7:0] ADR_STAT  = 8'h15;

	// node control register layout
	localparam int NC_FLAG = 7;
	localparam int NC_EN   = 6;
	localparam int NC_LVL  = 2;

	// values after reset
	localparam logic [15:0] NODE_RST = 16'h0000;
	localparam logic [15:0] MUX_RST  = 16'h0000;
	localparam logic [15:0] TFR_RST  = 16'h0000;

	// trap flag register bit positions
	localparam int TF_NMI  = 15;
	localparam int TF_STO  = 14;
	localparam int TF_STU  = 13;
	localparam int TF_UND  = 7;
	localparam int TF_MAC  = 4;
	localparam int TF_PRT  = 3;
	localparam int TF_OPA  = 2;
	localparam int TF_INA  = 1;
	localparam int TF_BUS  = 0;

	// trap numbers; vector location is four times the number
	localparam logic [6:0] TRAP_RST = 7'h00;
	localparam logic [6:0] TRAP_NMI = 7'h02;
	localparam logic [6:0] TRAP_STO = 7'h04;
	localparam logic [6:0] TRAP_STU = 7'h06;
	localparam logic [6:0] TRAP_CLB = 7'h0A;
	localparam logic [3:0] ILVL_MAX = 4'hF;

	// timer 6, capture reload, adc done, adc overrun, async 0 tx, tx buf,
	// rx, err, sync 0 tx, rx, err, pwm, extended vectors 0..3
	localparam logic [6:0] NODE_TRAP [NODES] = '{
		7'h26, 7'h27, 7'h28, 7'h29, 7'h2A, 7'h47, 7'h2B, 7'h2C,
		7'h2D, 7'h2E, 7'h2F, 7'h3F, 7'h40, 7'h41, 7'h42, 7'h43};

	// extended event indices; XE_NONE is a constant zero input
	localparam int XE_CAN1 = 0;
	localparam int XE_CAN2 = 1;
	localparam int XE_IRX  = 2;
	localparam int XE_ITX  = 3;
	localparam int XE_IER  = 4;
	localparam int XE_SRX  = 5;
	localparam int XE_STX  = 6;
	localparam int XE_SER  = 7;
	localparam int XE_ARX  = 8;
	localparam int XE_ATX  = 9;
	localparam int XE_ATB  = 10;
	localparam int XE_AER  = 11;
	localparam int XE_PLL  = 12;
	localparam int XE_PWM  = 13;
	localparam int XE_NONE = 14;

	// source of each flag bit of each multiplexer register
	localparam int MUX_MAP [NMUX][8] = '{
		'{XE_CAN1, XE_IRX, XE_ITX, XE_SRX, XE_STX, XE_ARX, XE_ATX, XE_ATB},
		'{XE_CAN2, XE_IRX, XE_ITX, XE_SRX, XE_STX, XE_ARX, XE_ATX, XE_ATB},
		'{XE_PWM, XE_IRX, XE_ITX, XE_SRX, XE_STX, XE_ARX, XE_ATX, XE_ATB},
		'{XE_CAN1, XE_CAN2, XE_IER, XE_SER, XE_AER, XE_PLL, XE_PWM,
			XE_NONE}};

	typedef enum logic [1:0] {RK_NONE, RK_B, RK_A} itv_rank_t;
	typedef enum logic [2:0] {
		K_NONE, K_RST, K_NMI, K_STO, K_STU, K_CLB, K_SWT, K_IRQ
	} itv_kind_t;

endpackage

// File: src/itv_wr_if.sv
// register write path shared by the control register modules
`timescale 1ns/10ps
interface itv_wr_if;
	logic        wr;
	logic [7:0]  addr;
	logic [15:0] wdata;
	modport src  (output wr, addr, wdata);
	modport sink (input wr, addr, wdata);
endinterface

// File: src/itv_node.sv
// control register of one interrupt node: flag, enable, level
`timescale 1ns/10ps
module itv_node #(
	parameter logic [7:0] ADDR = 8'h00
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// register writes
	itv_wr_if.sink           bus,
	// request set and service clear
	input  wire logic        i_evt,
	input  wire logic        i_ack,
	// state
	output logic      [15:0] o_ctrl,
	output logic             o_req,
	output logic      [3:0]  o_lvl
);
	logic        flag_r;
	logic        en_r;
	logic [3:0]  lvl_r;
	logic        flag_nxt;
	wire         hit = bus.wr && (bus.addr == ADDR);

	// event wins over both software write and service clear
	assign flag_nxt = i_evt | (hit ? bus.wdata[itv_pkg::NC_FLAG]
		: (flag_r & ~i_ack));

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			flag_r <= itv_pkg::NODE_RST[itv_pkg::NC_FLAG];
			en_r   <= itv_pkg::NODE_RST[itv_pkg::NC_EN];
			lvl_r  <= itv_pkg::NODE_RST[itv_pkg::NC_LVL +: 4];
		end else begin
			flag_r <= flag_nxt;
			if (hit) begin
				en_r  <= bus.wdata[itv_pkg::NC_EN];
				lvl_r <= bus.wdata[itv_pkg::NC_LVL +: 4];
			end
		end
	end

	assign o_ctrl = {8'h00, flag_r, en_r, lvl_r, 2'b00};
	assign o_req  = flag_r & en_r;
	assign o_lvl  = lvl_r;

	set_wins_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_evt |=> flag_r) else $error("node event lost");
endmodule

// File: src/itv_xmux.sv
// one extended vector multiplexer: enable byte over flag byte
`timescale 1ns/10ps
module itv_xmux #(
	parameter logic [7:0] ADDR = 8'h10
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// register writes
	itv_wr_if.sink           bus,
	// source events
	input  wire logic [7:0]  i_evt,
	// state
	output logic      [15:0] o_reg,
	output logic             o_req
);
	logic [7:0] en_r;
	logic [7:0] flag_r;
	wire        hit = bus.wr && (bus.addr == ADDR);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			en_r   <= itv_pkg::MUX_RST[15:8];
			flag_r <= itv_pkg::MUX_RST[7:0];
		end else begin
			// writing zero clears a flag; events set even if masked
			flag_r <= i_evt | (hit ? (flag_r & bus.wdata[7:0])
				: flag_r);
			if (hit)
				en_r <= bus.wdata[15:8];
		end
	end

	assign o_reg = {en_r, flag_r};
	assign o_req = |(en_r & flag_r);

	flag_poll_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_evt != 8'h00 |=> (flag_r & $past(i_evt)) == $past(i_evt))
		else $error("masked event not flagged");
	flag_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		flag_r[0] && !hit |=> flag_r[0])
		else $error("flag cleared by hardware");
endmodule

// File: src/itv_ctrl.sv
// interrupt and trap vectoring with extended vector multiplexers
`timescale 1ns/10ps
// Overview of operation
// - standard source vector is four times trap
// - hardware trap branches non-maskably to vector
// - each hardware trap except reset sets its trap flag bit
// - trap pre-empts unless equal or higher class trap serviced
// - trap service blocks interrupts
// - resets use vector zero, highest rank
// - class A traps at 08, 10, 18
// - class B traps share vector 28h
// - traps and reset force level fifteen
// - software trap any number, keeps level
// - four extended vectors at 100h..10Ch
// - mux bits fifteen..eight are enables
// - mux bits seven..zero are flags
// - enabled raised flag requests extended vector
// - flags set even when enable clear
// - can, i2c, sync, async routing fixed
// - pll and pwm unit 2 routing
// - each source: flag, enable, sixteen levels
// - only strictly higher level pre-empts service
module itv_ctrl (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	// standard and extended peripheral events
	input  wire logic [11:0] i_std_evt,
	input  wire logic [13:0] i_xevt,
	// trap events
	input  wire logic        i_sw_reset,
	input  wire logic        i_wdt_ovf,
	input  wire logic        i_nmi,
	input  wire logic        i_stk_ovf,
	input  wire logic        i_stk_unf,
	input  wire logic        i_undef_opc,
	input  wire logic        i_mac_trap,
	input  wire logic        i_prot_fault,
	input  wire logic        i_ill_operand,
	input  wire logic        i_ill_instr,
	input  wire logic        i_ill_bus,
	// software trap instruction
	input  wire logic        i_swtrap,
	input  wire logic [6:0]  i_swtrap_num,
	// cpu side
	input  wire logic [3:0]  i_cpu_ilvl,
	input  wire logic        i_vec_ack,
	input  wire logic        i_trap_done,
	output logic             o_vec_req,
	output logic      [15:0] o_vec_loc,
	output logic      [6:0]  o_trap_num,
	output logic      [3:0]  o_new_ilvl,
	output logic             o_is_trap,
	output logic             o_trap_active
);

	itv_wr_if wr_bus ();

	logic [15:0]         node_ctrl [itv_pkg::NODES];
	logic [3:0]          node_lvl [itv_pkg::NODES];
	logic [15:0]         node_req;
	logic [15:0]         node_evt;
	logic [15:0]         node_ack;
	logic [15:0]         mux_reg [itv_pkg::NMUX];
	logic [3:0]          xreq;
	logic [3:0]          xreq_prev_r;
	logic [14:0]         xevt_pad;

	logic [15:0]         tfr_r;
	logic [15:0]         tfr_set;
	logic                rst_pend_r;
	logic [2:0]          a_pend_r;
	logic                b_pend_r;
	logic                sw_pend_r;
	logic [6:0]          sw_num_r;
	itv_pkg::itv_rank_t  svc_r;
	itv_pkg::itv_rank_t  svc_nxt;
	itv_pkg::itv_kind_t  pres_kind_r;
	logic [3:0]          pres_node_r;

	itv_pkg::itv_kind_t  cand_kind;
	itv_pkg::itv_kind_t  pres_kind_nxt;
	logic [6:0]          cand_trap;
	logic [3:0]          cand_ilvl;
	logic                cand_is_trap;
	logic                a_ok;
	logic                b_ok;
	logic                best_ok;
	logic [3:0]          best_idx;
	logic [3:0]          best_lvl;
	logic [15:0]         rd_val;
	logic [15:0]         stat;

	// register write path to the control register modules
	assign wr_bus.wr    = i_wr;
	assign wr_bus.addr  = i_addr;
	assign wr_bus.wdata = i_wdata;

	// extended events padded with a constant zero source
	assign xevt_pad = {1'b0, i_xevt};

	// four identical multiplexers with fixed source routing
	for (genvar m = 0; m < itv_pkg::NMUX; m++) begin : g_mux
		logic [7:0] mevt;
		for (genvar b = 0; b < 8; b++) begin : g_bit
			assign mevt[b] = xevt_pad[itv_pkg::MUX_MAP[m][b]];
		end
		itv_xmux #(
			.ADDR (8'(itv_pkg::ADR_MUX0 + m))
		) u_xmux (
			.i_clk     (i_clk),
			.i_sys_rst (i_sys_rst),
			.bus       (wr_bus),
			.i_evt     (mevt),
			.o_reg     (mux_reg[m]),
			.o_req     (xreq[m])
		);
	end

	// extended node flag is set on a new multiplexer request only
	assign node_evt = {xreq & ~xreq_prev_r, i_std_evt};

	assign node_ack = (i_vec_ack && pres_kind_r == itv_pkg::K_IRQ)
		? (16'h0001 << pres_node_r) : 16'h0000;

	for (genvar n = 0; n < itv_pkg::NODES; n++) begin : g_node
		itv_node #(
			.ADDR (8'(itv_pkg::ADR_NODE0 + n))
		) u_node (
			.i_clk     (i_clk),
			.i_sys_rst (i_sys_rst),
			.bus       (wr_bus),
			.i_evt     (node_evt[n]),
			.i_ack     (node_ack[n]),
			.o_ctrl    (node_ctrl[n]),
			.o_req     (node_req[n]),
			.o_lvl     (node_lvl[n])
		);
	end

	// highest level above the cpu level; lowest index wins a tie
	always_comb begin
		best_ok  = 1'b0;
		best_idx = 4'h0;
		best_lvl = 4'h0;
		for (int i = 0; i < itv_pkg::NODES; i++) begin
			if (node_req[i] && node_lvl[i] > i_cpu_ilvl &&
					(!best_ok || node_lvl[i] > best_lvl)) begin
				best_ok  = 1'b1;
				best_idx = 4'(i);
				best_lvl = node_lvl[i];
			end
		end
	end

	// trap flag register: events set, writing zero clears
	assign tfr_set = {i_nmi, i_stk_ovf, i_stk_unf, 5'b0_0000,
		i_undef_opc, 2'b00, i_mac_trap, i_prot_fault, i_ill_operand,
		i_ill_instr, i_ill_bus};

	// ranking of pending work against the trap in service
	assign a_ok = (svc_r != itv_pkg::RK_A);
	assign b_ok = (svc_r == itv_pkg::RK_NONE);

	assign cand_kind =
		rst_pend_r                 ? itv_pkg::K_RST :
		(a_ok && a_pend_r[0])      ? itv_pkg::K_NMI :
		(a_ok && a_pend_r[1])      ? itv_pkg::K_STO :
		(a_ok && a_pend_r[2])      ? itv_pkg::K_STU :
		(b_ok && b_pend_r)         ? itv_pkg::K_CLB :
		sw_pend_r                  ? itv_pkg::K_SWT :
		(b_ok && best_ok)          ? itv_pkg::K_IRQ :
		itv_pkg::K_NONE;

	assign cand_trap =
		(cand_kind == itv_pkg::K_RST) ? itv_pkg::TRAP_RST :
		(cand_kind == itv_pkg::K_NMI) ? itv_pkg::TRAP_NMI :
		(cand_kind == itv_pkg::K_STO) ? itv_pkg::TRAP_STO :
		(cand_kind == itv_pkg::K_STU) ? itv_pkg::TRAP_STU :
		(cand_kind == itv_pkg::K_CLB) ? itv_pkg::TRAP_CLB :
		(cand_kind == itv_pkg::K_SWT) ? sw_num_r :
		itv_pkg::NODE_TRAP[best_idx];

	assign cand_is_trap = (cand_kind != itv_pkg::K_NONE) &&
		(cand_kind != itv_pkg::K_SWT) && (cand_kind != itv_pkg::K_IRQ);

	assign cand_ilvl =
		(cand_kind == itv_pkg::K_SWT) ? i_cpu_ilvl :
		(cand_kind == itv_pkg::K_IRQ) ? best_lvl :
		itv_pkg::ILVL_MAX;

	// one idle cycle follows each taken vector
	assign pres_kind_nxt = i_vec_ack ? itv_pkg::K_NONE : cand_kind;

	// rank of the trap in service after this cycle
	assign svc_nxt =
		(i_vec_ack && (pres_kind_r == itv_pkg::K_NMI ||
			pres_kind_r == itv_pkg::K_STO ||
			pres_kind_r == itv_pkg::K_STU)) ? itv_pkg::RK_A :
		(i_vec_ack && pres_kind_r == itv_pkg::K_CLB) ? itv_pkg::RK_B :
		(i_vec_ack && pres_kind_r == itv_pkg::K_RST) ? itv_pkg::RK_NONE :
		i_trap_done ? itv_pkg::RK_NONE : svc_r;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			tfr_r <= itv_pkg::TFR_RST;
		else if (i_wr && i_addr == itv_pkg::ADR_TFR)
			tfr_r <= tfr_set | (tfr_r & i_wdata);
		else
			tfr_r <= tfr_set | tfr_r;
	end

	// pending traps: events set, taking the vector clears, set wins
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rst_pend_r <= 1'b1;
			a_pend_r   <= 3'b000;
			b_pend_r   <= 1'b0;
		end else begin
			rst_pend_r <= i_sw_reset | i_wdt_ovf | (rst_pend_r &
				~(i_vec_ack && pres_kind_r == itv_pkg::K_RST));
			a_pend_r[0] <= i_nmi | (a_pend_r[0] &
				~(i_vec_ack && pres_kind_r == itv_pkg::K_NMI));
			a_pend_r[1] <= i_stk_ovf | (a_pend_r[1] &
				~(i_vec_ack && pres_kind_r == itv_pkg::K_STO));
			a_pend_r[2] <= i_stk_unf | (a_pend_r[2] &
				~(i_vec_ack && pres_kind_r == itv_pkg::K_STU));
			b_pend_r <= (|tfr_set[itv_pkg::TF_UND:itv_pkg::TF_BUS]) |
				(b_pend_r &
				~(i_vec_ack && pres_kind_r == itv_pkg::K_CLB));
		end
	end

	// software trap request held until the cpu takes it
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sw_pend_r <= 1'b0;
			sw_num_r  <= 7'h00;
		end else begin
			sw_pend_r <= i_swtrap | (sw_pend_r &
				~(i_vec_ack && pres_kind_r == itv_pkg::K_SWT));
			if (i_swtrap)
				sw_num_r <= i_swtrap_num;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			svc_r         <= itv_pkg::RK_NONE;
			o_trap_active <= 1'b0;
			xreq_prev_r   <= 4'h0;
		end else begin
			svc_r         <= svc_nxt;
			o_trap_active <= (svc_nxt != itv_pkg::RK_NONE);
			xreq_prev_r   <= xreq;
		end
	end

	// presented vector, registered toward the cpu
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pres_kind_r <= itv_pkg::K_NONE;
			pres_node_r <= 4'h0;
			o_vec_req   <= 1'b0;
			o_vec_loc   <= 16'h0000;
			o_trap_num  <= 7'h00;
			o_new_ilvl  <= 4'h0;
			o_is_trap   <= 1'b0;
		end else begin
			pres_kind_r <= pres_kind_nxt;
			pres_node_r <= best_idx;
			o_vec_req   <= (pres_kind_nxt != itv_pkg::K_NONE);
			o_vec_loc   <= {7'h00, cand_trap, 2'b00};
			o_trap_num  <= cand_trap;
			o_new_ilvl  <= cand_ilvl;
			o_is_trap   <= cand_is_trap && !i_vec_ack;
		end
	end

	// status: rank in service and pending work
	assign stat = {11'h000, sw_pend_r, b_pend_r, |a_pend_r, svc_r};

	// read decode; unmapped addresses read zero
	assign rd_val =
		(i_addr < itv_pkg::ADR_MUX0) ? node_ctrl[i_addr[3:0]] :
		(i_addr < itv_pkg::ADR_TFR)  ? mux_reg[i_addr[1:0]] :
		(i_addr == itv_pkg::ADR_TFR) ? tfr_r :
		(i_addr == itv_pkg::ADR_STAT) ? stat : 16'h0000;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_rdata <= 16'h0000;
		else
			o_rdata <= i_rd ? rd_val : 16'h0000;
	end

	vec_loc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_vec_req |-> o_vec_loc == {7'h00, o_trap_num, 2'b00})
		else $error("vector not four times trap");
	std_vec_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_vec_req && pres_kind_r == itv_pkg::K_IRQ && pres_node_r == 4'h5
		|-> o_vec_loc == 16'h011C && o_trap_num == 7'h47)
		else $error("standard vector location wrong");
	trap_flag_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_stk_ovf |=> tfr_r[itv_pkg::TF_STO])
		else $error("trap flag not set");
	trap_level_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_vec_req && o_is_trap |-> o_new_ilvl == 4'hF)
		else $error("trap level not forced");
	reset_vec_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_vec_req && pres_kind_r == itv_pkg::K_RST |->
		o_trap_num == 7'h00 && o_vec_loc == 16'h0000)
		else $error("reset vector wrong");
	class_b_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_vec_req && pres_kind_r == itv_pkg::K_CLB |->
		o_vec_loc == 16'h0028 && svc_r == itv_pkg::RK_NONE)
		else $error("class b vector wrong");
	nmi_rank_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_vec_req && pres_kind_r == itv_pkg::K_NMI |->
		svc_r != itv_pkg::RK_A && o_vec_loc == 16'h0008)
		else $error("nmi presented over class a");
	irq_block_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_trap_active && o_vec_req |-> pres_kind_r != itv_pkg::K_IRQ)
		else $error("interrupt during trap service");
	irq_level_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_vec_req && pres_kind_r == itv_pkg::K_IRQ |->
		o_new_ilvl > $past(i_cpu_ilvl))
		else $error("interrupt not above level");
	sw_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_vec_req && pres_kind_r == itv_pkg::K_SWT |->
		o_new_ilvl == $past(i_cpu_ilvl) && !o_is_trap)
		else $error("software trap changed level");
	ack_gap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_vec_ack |=> !o_vec_req)
		else $error("no idle cycle after ack");
	xvec_rise_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$rose(xreq[3]) |=> node_ctrl[15][itv_pkg::NC_FLAG])
		else $error("extended vector not requested");

endmodule

// File: testbench/itv_cpu_model.sv
// behavioural cpu side: takes presented vectors and tracks its level
`timescale 1ns/10ps
module itv_cpu_model (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	// presented vector
	input  wire logic       i_req,
	input  wire logic [3:0] i_new_ilvl,
	// bench control: stall, slow answer, service return
	input  wire logic       i_hold,
	input  wire logic       i_slow,
	input  wire logic       i_ret,
	// answers
	output logic            o_ack,
	output logic      [3:0] o_ilvl
);
	logic [1:0] wait_r;
	wire  [1:0] wait_max = i_slow ? 2'd3 : 2'd0;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_ack  <= 1'b0;
			wait_r <= 2'd0;
			o_ilvl <= 4'h0;
		end else if (o_ack) begin
			// vector taken at this edge: adopt its level
			o_ack  <= 1'b0;
			o_ilvl <= i_new_ilvl;
		end else begin
			if (i_ret) begin
				o_ilvl <= 4'h0;
			end
			if (i_req && !i_hold && wait_r == wait_max) begin
				o_ack  <= 1'b1;
				wait_r <= 2'd0;
			end else if (i_req && !i_hold) begin
				wait_r <= wait_r + 2'd1;
			end else begin
				wait_r <= 2'd0;
			end
		end
	end
endmodule

// File: testbench/interrupt_trap_vectoring_tb.sv
// self-checking bench for the interrupt and trap vectoring block
`timescale 1ns/10ps
module interrupt_trap_vectoring_tb;
	logic        i_clk, i_sys_rst, i_wr, i_rd, i_swtrap, hold, slow, ret;
	logic        ack, o_vec_req, o_is_trap, o_trap_active;
	logic [7:0]  i_addr;
	logic [15:0] i_wdata, o_rdata, o_vec_loc, rd_v;
	logic [11:0] i_std_evt;
	logic [13:0] i_xevt;
	logic [10:0] trp;
	logic [6:0]  i_swtrap_num, o_trap_num;
	logic [3:0]  cpu_lvl, o_new_ilvl;
	logic [31:0] got_w;
	logic [31:0] exp_q [$];
	int          error_cnt = 0, comparisons = 0, acks = 0, seed, n, m;
	logic [55:0] route = 56'hC8_8777_8778_77A9;
	logic [6:0]  std_trap [12] = '{7'h26, 7'h27, 7'h28, 7'h29, 7'h2A,
		7'h47, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h3F};
	logic [6:0]  tnum [11] = '{7'h00, 7'h00, 7'h02, 7'h04, 7'h06,
		7'h0A, 7'h0A, 7'h0A, 7'h0A, 7'h0A, 7'h0A};
	logic [15:0] tfr_exp [11] = '{16'h0000, 16'h0000, 16'h8000, 16'h4000,
		16'h2000, 16'h0080, 16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001};

	itv_ctrl itv_ctrl_inst (
		.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_std_evt, .i_xevt, .i_sw_reset(trp[0]), .i_wdt_ovf(trp[1]),
		.i_nmi(trp[2]), .i_stk_ovf(trp[3]), .i_stk_unf(trp[4]),
		.i_undef_opc(trp[5]), .i_mac_trap(trp[6]), .i_prot_fault(trp[7]),
		.i_ill_operand(trp[8]), .i_ill_instr(trp[9]), .i_ill_bus(trp[10]),
		.i_swtrap, .i_swtrap_num, .i_cpu_ilvl(cpu_lvl), .i_vec_ack(ack),
		.i_trap_done(ret), .o_vec_req, .o_vec_loc, .o_trap_num, .o_new_ilvl,
		.o_is_trap, .o_trap_active);

	itv_cpu_model itv_cpu_model_inst (
		.i_clk, .i_sys_rst, .i_req(o_vec_req), .i_new_ilvl(o_new_ilvl),
		.i_hold(hold), .i_slow(slow), .i_ret(ret), .o_ack(ack),
		.o_ilvl(cpu_lvl));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	function automatic logic [31:0] ev(input logic [6:0] t,
		input logic [3:0] l, input logic k);
		return {7'h00, t, 2'b00, 1'b0, t, 3'b000, k, l};
	endfunction

	// flag byte one extended event leaves in one multiplexer
	function automatic logic [7:0] xf(input int mx, e);
		logic [7:0] f;
		f = 8'h00;
		for (int b = 0; b < 8; b++) begin
			if (itv_pkg::MUX_MAP[mx][b] == e && route[4 * e + mx]) f[b] = 1'b1;
		end
		return f;
	endfunction

	task chk(input logic [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		rd_v = o_rdata;
	endtask

	task ev_pulse(input logic [10:0] t, input logic [11:0] s,
		input logic [13:0] x);
		@(posedge i_clk);
		trp       <= t;
		i_std_evt <= s;
		i_xevt    <= x;
		@(posedge i_clk);
		trp       <= '0;
		i_std_evt <= '0;
		i_xevt    <= '0;
	endtask

	task wait_ack;
		int c, k;
		c = acks;
		k = 0;
		while (acks == c && k < 80) begin
			@(posedge i_clk);
			k++;
		end
		if (acks == c) chk(32'h0000_0000, 32'h0000_0001);
	endtask

	task ret_pulse;
		@(posedge i_clk);
		ret <= 1'b1;
		@(posedge i_clk);
		ret <= 1'b0;
	endtask

	task drain(input int cnt);
		repeat (cnt) begin
			wait_ack();
			ret_pulse();
		end
	endtask

	task report_and_stop;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// every taken vector against the model queue
	assign got_w = {o_vec_loc, 1'b0, o_trap_num, 3'b000, o_is_trap, o_new_ilvl};
	always @(posedge i_clk) begin
		if (ack === 1'b1 && o_vec_req === 1'b1) begin
			acks <= acks + 1;
			chk(got_w, exp_q.size() ? exp_q.pop_front() : ~got_w);
		end
	end

	initial begin
		#(100 * 30000);
		error_cnt++;
		report_and_stop();
	end

	initial begin
		seed = 32'h40db_2c97;
		{i_sys_rst, i_wr, i_rd, i_swtrap, hold, slow, ret} = 7'h40;
		{i_addr, i_wdata, i_std_evt, i_xevt, trp, i_swtrap_num} = '0;
		exp_q.push_back(ev(7'h00, 4'hF, 1'b1));
		repeat (16) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		drain(1);
		for (n = 0; n < 24; n++) begin
			rd(n[7:0]);
			chk(rd_v, 16'h0000);
		end
		for (n = 0; n < 12; n++) begin
			slow <= n[0];
			wr(n[7:0], 16'(16'h0040 | (n + 1) << 2));
			exp_q.push_back(ev(std_trap[n], 4'(n + 1), 1'b0));
			ev_pulse('0, 12'(1 << n), '0);
			drain(1);
		end
		// equal level held, software trap keeps cpu level
		wr(8'h01, 16'h0054);
		wr(8'h02, 16'h0054);
		wr(8'h03, 16'h0058);
		exp_q.push_back(ev(7'h27, 4'h5, 1'b0));
		ev_pulse('0, 12'h002, '0);
		wait_ack();
		for (m = 0; m < 2; m++) begin
			n = m ? 127 : {$random(seed)} % 126 + 1;
			exp_q.push_back(ev(n[6:0], 4'h5, 1'b0));
			@(posedge i_clk);
			i_swtrap     <= 1'b1;
			i_swtrap_num <= n[6:0];
			@(posedge i_clk);
			i_swtrap <= 1'b0;
			wait_ack();
		end
		ev_pulse('0, 12'h004, '0);
		repeat (8) @(posedge i_clk);
		exp_q.push_back(ev(7'h29, 4'h6, 1'b0));
		ev_pulse('0, 12'h008, '0);
		wait_ack();
		ret_pulse();
		exp_q.push_back(ev(7'h28, 4'h5, 1'b0));
		drain(1);
		for (n = 0; n < 11; n++) begin
			exp_q.push_back(ev(tnum[n], 4'hF, 1'b1));
			ev_pulse(11'(1 << n), '0, '0);
			drain(1);
			rd(itv_pkg::ADR_TFR);
			chk(rd_v, tfr_exp[n]);
			wr(itv_pkg::ADR_TFR, 16'h0000);
		end
		// nmi beats class b; interrupt waits for trap service
		hold <= 1'b1;
		wr(8'h00, 16'h0044);
		exp_q.push_back(ev(7'h02, 4'hF, 1'b1));
		exp_q.push_back(ev(7'h0A, 4'hF, 1'b1));
		exp_q.push_back(ev(7'h26, 4'h1, 1'b0));
		ev_pulse(11'h024, 12'h001, '0);
		rd(8'h15);
		chk(rd_v, 16'h000C);
		repeat (4) @(posedge i_clk);
		hold <= 1'b0;
		wait_ack();
		repeat (6) @(posedge i_clk);
		chk(o_trap_active, 1'b1);
		ret_pulse();
		wait_ack();
		exp_q.push_front(ev(7'h06, 4'hF, 1'b1));
		ev_pulse(11'h010, '0, '0);
		wait_ack();
		ret_pulse();
		drain(1);
		chk(o_trap_active, 1'b0);
		rd(itv_pkg::ADR_TFR);
		chk(rd_v, 16'hA080);
		wr(itv_pkg::ADR_TFR, 16'h0000);
		// each extended event alone, enables clear
		for (n = 0; n < 14; n++) begin
			ev_pulse('0, '0, 14'(1 << n));
			for (m = 0; m < 4; m++) begin
				rd(8'h10 + m[7:0]);
				chk(rd_v, {8'h00, xf(m, n)});
				chk(|xf(m, n), route[4 * n + m]);
				wr(8'h10 + m[7:0], 16'h0000);
			end
		end
		for (m = 0; m < 4; m++) begin
			wr(8'h10 + m[7:0], 16'hFF00);
			wr(8'h0C + m[7:0], 16'h004C);
			exp_q.push_back(ev(7'h40 + 7'(m), 4'h3, 1'b0));
		end
		ev_pulse('0, '0, 14'h1004);
		drain(4);
		rd(8'h13);
		chk(rd_v, 16'hFF00 | 16'(xf(3, 12)));
		wr(8'h13, 16'hFF00);
		rd(8'h13);
		chk(rd_v, 16'hFF00);
		chk(exp_q.size(), 0);
		report_and_stop();
	end
endmodule
